// >>> logic/wlt_table_mgr.sv
`timescale 1ns/1ps
// Functional notes
// [RULE1] Dwell series read returns up to 16 values
// [RULE2] Fill count read gives filled dwell locations
// [RULE3] Readback start set moves series start
// [RULE4] Readback start read returns current start
// [RULE5] Segment copy appends dwell copies, new level
// [RULE6] Copy without levels or bad indices: -221
// [RULE7] Copy with unequal list lengths: -226
// [RULE8] Resolution read gives bounds and point count
// [RULE9] Dwell outside 93 us to 34 ms rejected
// [RULE10] Averaging count rounded down to power two
// [RULE11] Sample insert appends averaging count points
// [RULE12] Sample insert without width: -221
// [RULE13] Sample insert needs prior level or width; code requires the width, with or without a level
// [RULE14] Sample insert with unequal lengths: -226
// [RULE15] Ninth sample insert per list: -223
// [RULE16] Sample points beyond 3933 total: -223
// [RULE17] Sample read gives indices then V/C
// [RULE18] Width set once in range, again: -100
// [RULE19] Width read before set gives error 100
// [RULE20] Single dwell entry applies to all steps
// [RULE21] Commands during list execution give -221
// [RULE22] Errors queue in order; table left unchanged
// [RULE23] Level and dwell lists share one index
module wlt_table_mgr
    import wlt_pkg::*;
(
    // Clock and reset.
    input  wire  logic             SYS_CLK,
    input  wire  logic             RSTN,
    // Command port.
    input  wire  logic             CMD_VALID,
    output logic                   CMD_READY,
    input  wire  wlt_op_t          CMD_OP,
    input  wire  logic [IDX_W-1:0] CMD_ARG_A,
    input  wire  logic [IDX_W-1:0] CMD_ARG_B,
    input  wire  logic [TIM_W-1:0] CMD_TIME,
    input  wire  logic [LVL_W-1:0] CMD_LEVEL,
    input  wire  logic             CMD_LEVEL_OK,
    input  wire  logic             CMD_IS_VOLT,
    // Answer port.
    output logic                   RSP_VALID,
    output logic [TIM_W-1:0]       RSP_DATA,
    output logic                   RSP_LAST,
    output logic                   RSP_EMPTY,
    output logic [7:0]             RSP_TAG,
    // Error queue.
    output logic                   ERR_VALID,
    output logic                   ERR_AVAIL,
    output logic [ERR_W-1:0]       ERR_CODE,
    input  wire  logic             ERR_POP,
    // Execution side.
    input  wire  logic             LIST_RUN,
    input  wire  logic             RES_MAX,
    input  wire  logic [IDX_W-1:0] EXEC_STEP,
    output logic [TIM_W-1:0]       EXEC_DWELL
);

    ////////////////////////////////////////////////////////////////////////////
    logic [LVL_W-1:0] level_mem [CAP_DEPTH];
    logic [TIM_W-1:0] dwell_mem [CAP_DEPTH];
    logic [IDX_W-1:0] samp_idx_r [8];
    logic [ERR_W-1:0] err_q_r [ERRQ_DEPTH];

    wlt_state_t       state_r;
    wlt_kind_t        kind_r;
    logic [IDX_W-1:0] lvl_cnt_r, dw_cnt_r, qstart_r, ptr_r, end_r, left_r;
    logic [LVL_W-1:0] hold_lvl_r;
    logic [TIM_W-1:0] width_r;
    logic             width_set_r, is_volt_r;
    logic [3:0]       samp_n_r;
    logic [2:0]       eq_wr_r, eq_rd_r;
    logic [3:0]       eq_cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the command in the idle state.
    wire              acc       = CMD_VALID && (state_r == ST_IDLE);
    wire [IDX_W-1:0]  cap       = RES_MAX ? CAP_MAX_RES : CAP_MIN_RES;
    wire              len_diff  = (lvl_cnt_r != dw_cnt_r);
    wire              dw_bad    = (CMD_TIME < DWELL_MIN_NS) || (CMD_TIME > DWELL_MAX_NS);
    wire              sw_bad    = (CMD_TIME < SWID_MIN_NS) || (CMD_TIME > SWID_MAX_NS);
    wire              idx_bad   = (CMD_ARG_A > CMD_ARG_B) || (CMD_ARG_B >= dw_cnt_r);
    wire [IDX_W-1:0]  avg       = (CMD_ARG_A >= AVG_MAX)        ? AVG_MAX        : // RULE10
                                  (CMD_ARG_A >= 13'd128)        ? 13'd128        :
                                  (CMD_ARG_A >= 13'd64)         ? 13'd64         :
                                  (CMD_ARG_A >= 13'd32)         ? 13'd32         :
                                  (CMD_ARG_A >= 13'd16)         ? 13'd16         :
                                  (CMD_ARG_A >= 13'd8)          ? 13'd8          :
                                  (CMD_ARG_A >= 13'd4)          ? 13'd4          : AVG_MIN;
    wire [IDX_W:0]    samp_tot  = {1'b0, lvl_cnt_r} + {1'b0, avg};
    wire              is_samp   = (CMD_OP == OP_CURRENT_SAMPLE_INSERT) || (CMD_OP == OP_VOLTAGE_SAMPLE_INSERT);
    wire [IDX_W-1:0]  q_last    = qstart_r + SERIES_MAX - 13'd1;
    wire [IDX_W-1:0]  d_last    = (q_last < dw_cnt_r) ? q_last : dw_cnt_r - 13'd1; // RULE1

    logic             err_hit;
    logic [ERR_W-1:0] err_code;
    always_comb begin
        err_hit  = 1'b0;
        err_code = ERR_SETTINGS;
        if (LIST_RUN) begin
            err_hit = 1'b1; // RULE21
        end else begin
            case (CMD_OP)
                OP_LEVEL_APPEND: begin
                    err_hit  = (lvl_cnt_r == cap);
                    err_code = ERR_TOO_MUCH;
                end
                OP_DWELL_TIME_APPEND: begin
                    err_hit  = dw_bad || (dw_cnt_r == cap); // RULE9
                    err_code = dw_bad ? ERR_RANGE : ERR_TOO_MUCH;
                end
                OP_SEGMENT_COPY_APPEND: begin
                    err_hit  = (lvl_cnt_r == 13'd0) || idx_bad || len_diff; // RULE6 RULE7
                    err_code = ((lvl_cnt_r == 13'd0) || idx_bad) ? ERR_SETTINGS : ERR_LENGTH;
                end
                OP_CURRENT_SAMPLE_INSERT, OP_VOLTAGE_SAMPLE_INSERT: begin
                    err_hit = 1'b1;
                    if (!width_set_r || (lvl_cnt_r == 13'd0 && !width_set_r)) begin
                        err_code = ERR_SETTINGS; // RULE12 RULE13
                    end else if (len_diff) begin
                        err_code = ERR_LENGTH; // RULE14
                    end else if (samp_n_r == SAMP_MAX || samp_tot > {1'b0, CAP_MIN_RES}) begin
                        err_code = ERR_TOO_MUCH; // RULE15 RULE16
                    end else begin
                        err_hit = 1'b0;
                    end
                end
                OP_SAMPLE_WIDTH_SET: begin
                    err_hit  = width_set_r || sw_bad; // RULE18
                    err_code = width_set_r ? ERR_COMMAND : ERR_RANGE;
                end
                OP_SAMPLE_WIDTH_READ: begin
                    err_hit  = !width_set_r; // RULE19
                    err_code = ERR_NOT_SET;
                end
                default: err_hit = 1'b0;
            endcase
        end
    end

    wire ok = acc && !err_hit; // RULE22
    wire copy_go = ok && (CMD_OP == OP_SEGMENT_COPY_APPEND) && CMD_LEVEL_OK && (lvl_cnt_r != cap);
    wire samp_go = ok && is_samp;

    ////////////////////////////////////////////////////////////////////////////
    // Table write port. Both lists are written at their own fill count, which
    // in the copy and fill states is one and the same location.
    wire moving   = (state_r == ST_COPY) || (state_r == ST_FILL);
    wire lvl_we   = (ok && CMD_OP == OP_LEVEL_APPEND) || moving;
    wire dw_we    = (ok && CMD_OP == OP_DWELL_TIME_APPEND) || moving;
    wire [TIM_W-1:0] dw_wd = (state_r == ST_COPY) ? dwell_mem[ptr_r] :
                             (state_r == ST_FILL) ? width_r : CMD_TIME;
    wire [LVL_W-1:0] lvl_wd = moving ? hold_lvl_r : CMD_LEVEL;
    wire step_end = (state_r == ST_COPY) ? (ptr_r == end_r) || (lvl_cnt_r + 13'd1 == cap) : (left_r == 13'd1);

    always_ff @(posedge SYS_CLK) begin
        if (lvl_we) level_mem[lvl_cnt_r] <= lvl_wd; // RULE23
        if (dw_we) dwell_mem[dw_cnt_r] <= dw_wd;
    end

    wire [TIM_W-1:0] res_word = (ptr_r == 13'd0) ? (RES_MAX ? DWELL_MAX_NS : DWELL_MIN_NS) :
                                (ptr_r == 13'd1) ? (RES_MAX ? DWELL_MIN_NS : DWELL_MAX_NS) :
                                {{(TIM_W-IDX_W){1'b0}}, cap}; // RULE8
    wire [TIM_W-1:0] ser_word = (kind_r == SK_DWELL) ? dwell_mem[ptr_r] :
                                (kind_r == SK_SAMPLE) ? {{(TIM_W-IDX_W){1'b0}}, samp_idx_r[ptr_r[2:0]]} : res_word;
    wire             ser_last = (ptr_r == end_r);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            state_r <= ST_IDLE;
            kind_r <= SK_DWELL;
            lvl_cnt_r <= 13'd0;
            dw_cnt_r <= 13'd0;
            qstart_r <= 13'd0;
            ptr_r <= 13'd0;
            end_r <= 13'd0;
            left_r <= 13'd0;
            hold_lvl_r <= 16'h0000;
            width_r <= 26'h0000000;
            width_set_r <= 1'b0;
            is_volt_r <= 1'b0;
            samp_n_r <= 4'd0;
            RSP_VALID <= 1'b0;
            RSP_DATA <= 26'h0000000;
            RSP_LAST <= 1'b0;
            RSP_EMPTY <= 1'b0;
            RSP_TAG <= 8'h00;
            EXEC_DWELL <= 26'h0000000;
        end else begin
            RSP_VALID <= 1'b0;
            RSP_LAST <= 1'b0;
            RSP_EMPTY <= 1'b0;
            RSP_TAG <= 8'h00;
            // With one dwell entry every executed step uses location zero.
            EXEC_DWELL <= (dw_cnt_r == 13'd1) ? dwell_mem[0] : dwell_mem[EXEC_STEP]; // RULE20
            if (lvl_we) lvl_cnt_r <= lvl_cnt_r + 13'd1;
            if (dw_we) dw_cnt_r <= dw_cnt_r + 13'd1; // RULE2
            case (state_r)
                ST_IDLE: begin
                    if (ok) begin
                        case (CMD_OP)
                            OP_LEVEL_APPEND: is_volt_r <= CMD_IS_VOLT;
                            OP_READBACK_START_SET: qstart_r <= CMD_ARG_A; // RULE3
                            OP_SAMPLE_WIDTH_SET: begin
                                width_r <= CMD_TIME;
                                width_set_r <= 1'b1; // RULE18
                            end
                            OP_DWELL_FILL_COUNT_READ, OP_READBACK_START_READ, OP_SAMPLE_WIDTH_READ: begin
                                RSP_VALID <= 1'b1;
                                RSP_LAST <= 1'b1;
                                RSP_DATA <= (CMD_OP == OP_SAMPLE_WIDTH_READ) ? width_r : // RULE19
                                            (CMD_OP == OP_DWELL_FILL_COUNT_READ) ?
                                            {{(TIM_W-IDX_W){1'b0}}, dw_cnt_r} :
                                            {{(TIM_W-IDX_W){1'b0}}, qstart_r}; // RULE4
                            end
                            OP_DWELL_SERIES_READ: begin
                                if (qstart_r >= dw_cnt_r) begin
                                    RSP_VALID <= 1'b1;
                                    RSP_LAST <= 1'b1;
                                    RSP_EMPTY <= 1'b1;
                                end else begin
                                    state_r <= ST_SERIES;
                                    kind_r <= SK_DWELL;
                                    ptr_r <= qstart_r;
                                    end_r <= d_last;
                                end
                            end
                            OP_SAMPLE_POINTS_READ: begin
                                if (samp_n_r == 4'd0) begin
                                    RSP_VALID <= 1'b1;
                                    RSP_LAST <= 1'b1;
                                    RSP_EMPTY <= 1'b1;
                                    RSP_TAG <= is_volt_r ? TAG_VOLT : TAG_CURR;
                                end else begin
                                    state_r <= ST_SERIES;
                                    kind_r <= SK_SAMPLE;
                                    ptr_r <= 13'd0;
                                    end_r <= {9'd0, samp_n_r} - 13'd1;
                                end
                            end
                            OP_RESOLUTION_READ: begin
                                state_r <= ST_SERIES;
                                kind_r <= SK_RES;
                                ptr_r <= 13'd0;
                                end_r <= 13'd2;
                            end
                            default: ;
                        endcase
                        if (copy_go) begin
                            state_r <= ST_COPY; // RULE5
                            ptr_r <= CMD_ARG_A;
                            end_r <= CMD_ARG_B;
                            hold_lvl_r <= CMD_LEVEL;
                        end
                        if (samp_go) begin
                            state_r <= ST_FILL; // RULE11
                            left_r <= avg;
                            hold_lvl_r <= CMD_LEVEL;
                            is_volt_r <= (CMD_OP == OP_VOLTAGE_SAMPLE_INSERT);
                            samp_idx_r[samp_n_r[2:0]] <= lvl_cnt_r;
                            samp_n_r <= samp_n_r + 4'd1; // RULE15
                        end
                    end
                end
                ST_COPY, ST_FILL: begin
                    ptr_r <= ptr_r + 13'd1;
                    left_r <= left_r - 13'd1;
                    if (step_end) state_r <= ST_IDLE;
                end
                ST_SERIES: begin
                    RSP_VALID <= 1'b1;
                    RSP_DATA <= ser_word;
                    RSP_LAST <= ser_last;
                    RSP_TAG <= (ser_last && kind_r == SK_SAMPLE) ? (is_volt_r ? TAG_VOLT : TAG_CURR) : 8'h00; // RULE17
                    ptr_r <= ptr_r + 13'd1;
                    if (ser_last) state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error queue. A push into a full queue is dropped so older codes survive.
    wire eq_push = acc && err_hit && (eq_cnt_r != ERRQ_DEPTH[3:0]);
    wire eq_pop  = ERR_POP && (eq_cnt_r != 4'd0);
    assign ERR_AVAIL = (eq_cnt_r != 4'd0);
    assign ERR_CODE  = err_q_r[eq_rd_r];
    assign CMD_READY = (state_r == ST_IDLE);

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            eq_wr_r <= 3'd0;
            eq_rd_r <= 3'd0;
            eq_cnt_r <= 4'd0;
            ERR_VALID <= 1'b0;
            for (int i = 0; i < ERRQ_DEPTH; i++) err_q_r[i] <= 16'h0000;
        end else begin
            ERR_VALID <= acc && err_hit;
            if (eq_push) begin
                err_q_r[eq_wr_r] <= err_code; // RULE22
                eq_wr_r <= eq_wr_r + 3'd1;
            end
            if (eq_pop) eq_rd_r <= eq_rd_r + 3'd1;
            eq_cnt_r <= eq_cnt_r + {3'd0, eq_push} - {3'd0, eq_pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [4:0] ser_words;
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN || state_r != ST_SERIES) ser_words <= 5'd0;
        else ser_words <= ser_words + 5'd1;
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    property p_series_len; ser_words <= 5'd16; endproperty
    a_series_len: assert property (p_series_len) else $error("series longer than 16 words"); // RULE1
    property p_fill_max; dw_cnt_r <= CAP_MAX_RES && lvl_cnt_r <= CAP_MAX_RES; endproperty
    a_fill_max: assert property (p_fill_max) else $error("fill count beyond capacity"); // RULE2
    property p_qstart; ok && CMD_OP == OP_READBACK_START_SET |=> qstart_r == $past(CMD_ARG_A); endproperty
    a_qstart: assert property (p_qstart) else $error("readback start not taken"); // RULE3
    property p_dwell_rej; acc && CMD_OP == OP_DWELL_TIME_APPEND && dw_bad |=> $stable(dw_cnt_r) && ERR_VALID; endproperty
    a_dwell_rej: assert property (p_dwell_rej) else $error("out of range dwell was stored"); // RULE9
    property p_run_rej; acc && LIST_RUN && eq_cnt_r != 4'd8
        |=> ERR_VALID && err_q_r[$past(eq_wr_r)] == ERR_SETTINGS; endproperty
    a_run_rej: assert property (p_run_rej) else $error("command during execution not refused"); // RULE21
    property p_copy_err; acc && !LIST_RUN && CMD_OP == OP_SEGMENT_COPY_APPEND && lvl_cnt_r == 13'd0
        |=> ERR_VALID ##1 state_r == ST_IDLE; endproperty
    a_copy_err: assert property (p_copy_err) else $error("copy without levels not refused"); // RULE6
    property p_width_twice; acc && !LIST_RUN && CMD_OP == OP_SAMPLE_WIDTH_SET && width_set_r
        |=> ERR_VALID && $stable(width_r); endproperty
    a_width_twice: assert property (p_width_twice) else $error("second width set not refused"); // RULE18
    property p_samp_cap; samp_n_r <= SAMP_MAX; endproperty
    a_samp_cap: assert property (p_samp_cap) else $error("more than eight sample inserts"); // RULE15
    property p_fill_len; samp_go |=> state_r == ST_FILL [*2]; endproperty
    a_fill_len: assert property (p_fill_len) else $error("sample fill ended early"); // RULE11
    property p_single_dwell; dw_cnt_r == 13'd1 && !dw_we |=> EXEC_DWELL == dwell_mem[0]; endproperty
    a_single_dwell: assert property (p_single_dwell) else $error("single dwell not applied"); // RULE20

    c_copy: cover property (state_r == ST_COPY ##1 state_r == ST_IDLE);
    c_series16: cover property (ser_words == 5'd15 && RSP_VALID);
    c_ninth: cover property (samp_n_r == SAMP_MAX && acc && is_samp);
    c_err_full: cover property (eq_cnt_r == ERRQ_DEPTH[3:0]);

endmodule : wlt_table_mgr

// >>> logic/wlt_pkg.sv
package wlt_pkg;
    // Widths of the table index, level words, time words and error codes.
    localparam int IDX_W  = 13;
    localparam int LVL_W  = 16;
    localparam int TIM_W  = 26;
    localparam int ERR_W  = 16;

    // Table capacities at the two resolutions and per-command limits.
    localparam logic [IDX_W-1:0] CAP_MAX_RES = 13'd5900;
    localparam logic [IDX_W-1:0] CAP_MIN_RES = 13'd3933;
    localparam int               CAP_DEPTH   = 5900;
    localparam logic [IDX_W-1:0] SERIES_MAX  = 13'd16;
    localparam logic [3:0]       SAMP_MAX    = 4'd8;
    localparam logic [IDX_W-1:0] AVG_MIN     = 13'd2;
    localparam logic [IDX_W-1:0] AVG_MAX     = 13'd256;

    // Times are carried in nanoseconds.
    localparam logic [TIM_W-1:0] DWELL_MIN_NS = 26'd93000;
    localparam logic [TIM_W-1:0] DWELL_MAX_NS = 26'd34000000;
    localparam logic [TIM_W-1:0] SWID_MIN_NS  = 26'd250000;
    localparam logic [TIM_W-1:0] SWID_MAX_NS  = 26'd34000000;

    // Error codes, two's complement.
    localparam logic [ERR_W-1:0] ERR_COMMAND  = 16'hFF9C;
    localparam logic [ERR_W-1:0] ERR_SETTINGS = 16'hFF23;
    localparam logic [ERR_W-1:0] ERR_RANGE    = 16'hFF22;
    localparam logic [ERR_W-1:0] ERR_TOO_MUCH = 16'hFF21;
    localparam logic [ERR_W-1:0] ERR_LENGTH   = 16'hFF1E;
    localparam logic [ERR_W-1:0] ERR_NOT_SET  = 16'h0064;
    localparam int               ERRQ_DEPTH   = 8;

    // List type letters returned with the last word of the sample point series.
    localparam logic [7:0] TAG_VOLT = 8'h56;
    localparam logic [7:0] TAG_CURR = 8'h43;

    typedef enum logic [3:0] {
        OP_LEVEL_APPEND, OP_DWELL_TIME_APPEND, OP_DWELL_SERIES_READ, OP_DWELL_FILL_COUNT_READ,
        OP_READBACK_START_SET, OP_READBACK_START_READ, OP_SEGMENT_COPY_APPEND, OP_RESOLUTION_READ,
        OP_CURRENT_SAMPLE_INSERT, OP_VOLTAGE_SAMPLE_INSERT, OP_SAMPLE_POINTS_READ,
        OP_SAMPLE_WIDTH_SET, OP_SAMPLE_WIDTH_READ
    } wlt_op_t;

    typedef enum {ST_IDLE, ST_COPY, ST_FILL, ST_SERIES} wlt_state_t;
    typedef enum logic [1:0] {SK_DWELL, SK_SAMPLE, SK_RES} wlt_kind_t;
endpackage : wlt_pkg

// >>> tb/wlt_host_model.sv
`timescale 1ns/1ps
// Host on the command port: one command at a time, held until taken.
// Released argument, time and level fields are inverted so that no stale value can pass for a new one.
module wlt_host_model
    import wlt_pkg::*;
(
    // Clock and handshake.
    input  wire logic             SYS_CLK,
    input  wire logic             CMD_READY,
    output logic                  CMD_VALID,
    // Command fields.
    output wlt_op_t               CMD_OP,
    output logic [IDX_W-1:0]      CMD_ARG_A,
    output logic [IDX_W-1:0]      CMD_ARG_B,
    output logic [TIM_W-1:0]      CMD_TIME,
    output logic [LVL_W-1:0]      CMD_LEVEL,
    output logic                  CMD_LEVEL_OK,
    output logic                  CMD_IS_VOLT,
    output logic                  hung
);
    initial begin
        {CMD_VALID, CMD_ARG_A, CMD_ARG_B, CMD_TIME, CMD_LEVEL, CMD_IS_VOLT, hung} = '0;
        CMD_OP       = OP_LEVEL_APPEND;
        CMD_LEVEL_OK = 1'b1;
    end

    task send(input wlt_op_t op, input logic [IDX_W-1:0] a, b, input logic [TIM_W-1:0] t,
              input logic [LVL_W-1:0] l);
        int i;
        @(posedge SYS_CLK);
        #1;
        CMD_OP = op;
        {CMD_VALID, CMD_ARG_A, CMD_ARG_B, CMD_TIME, CMD_LEVEL} = {1'b1, a, b, t, l};
        for (i = 0; i < 600; i++) begin
            @(posedge SYS_CLK);
            if (CMD_READY === 1'b1) break;
        end
        hung = hung | (i == 600);
        #1;
        {CMD_VALID, CMD_ARG_A, CMD_ARG_B, CMD_TIME, CMD_LEVEL} = {1'b0, ~a, ~b, ~t, ~l};
    endtask : send
endmodule : wlt_host_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench
    import wlt_pkg::*;
;
    logic sys_clk = 1'b0, rstn = 1'b0, err_pop = 1'b0, list_run = 1'b0, res_max = 1'b0;
    logic [IDX_W-1:0] exec_step = '0;
    wire  cmd_valid, cmd_ready, lvl_ok, is_volt, rsp_valid, rsp_last, rsp_empty, err_valid, err_avail;
    wire  wlt_op_t cmd_op;
    wire  [IDX_W-1:0] arg_a, arg_b;
    wire  [TIM_W-1:0] cmd_time, rsp_data, exec_dwell;
    wire  [LVL_W-1:0] cmd_level;
    wire  [7:0] rsp_tag;
    wire  [ERR_W-1:0] err_code;
    int   err_count = 0, n_compared = 0;
    logic [TIM_W-1:0] rq[$];
    logic [7:0] last_tag;
    logic       last_empty;
    wlt_host_model host (.SYS_CLK(sys_clk), .CMD_READY(cmd_ready), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_ARG_A(arg_a), .CMD_ARG_B(arg_b), .CMD_TIME(cmd_time), .CMD_LEVEL(cmd_level),
        .CMD_LEVEL_OK(lvl_ok), .CMD_IS_VOLT(is_volt), .hung());
    wlt_table_mgr dut (.SYS_CLK(sys_clk), .RSTN(rstn), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
        .CMD_OP(cmd_op), .CMD_ARG_A(arg_a), .CMD_ARG_B(arg_b), .CMD_TIME(cmd_time), .CMD_LEVEL(cmd_level),
        .CMD_LEVEL_OK(lvl_ok), .CMD_IS_VOLT(is_volt), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
        .RSP_LAST(rsp_last), .RSP_EMPTY(rsp_empty), .RSP_TAG(rsp_tag), .ERR_VALID(err_valid),
        .ERR_AVAIL(err_avail), .ERR_CODE(err_code), .ERR_POP(err_pop), .LIST_RUN(list_run),
        .RES_MAX(res_max), .EXEC_STEP(exec_step), .EXEC_DWELL(exec_dwell));
    always #5 sys_clk = ~sys_clk;
    // Answer words are collected mid-cycle, away from the launching edge.
    always @(negedge sys_clk) if (rsp_valid === 1'b1) begin
        rq.push_back(rsp_data);
        if (rsp_last === 1'b1) {last_tag, last_empty} = {rsp_tag, rsp_empty};
    end
////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    task check(input string what, input logic [TIM_W-1:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task cmd(input wlt_op_t op, input logic [IDX_W-1:0] a, b, input logic [TIM_W-1:0] t, input logic [LVL_W-1:0] l);
        rq.delete();
        host.send(op, a, b, t, l);
        if (host.hung) begin
            err_count++;
            stop_test();
        end
    endtask : cmd
    task want(input int n, input logic [TIM_W-1:0] e0, e1, e2);
        int i;
        for (i = 0; i < 60 && rq.size() < n; i++) @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
        check("word count", TIM_W'(rq.size()), TIM_W'(n));
        if (rq.size() > 0) check("word 0", rq[0], e0);
        if (n > 1 && rq.size() > 1) check("word 1", rq[1], e1);
        if (n > 2 && rq.size() > 2) check("word 2", rq[2], e2);
    endtask : want
    task err(input logic [ERR_W-1:0] e);
        int i;
        for (i = 0; i < 20 && err_avail !== 1'b1; i++) @(negedge sys_clk);
        check("error flags", {24'h0, err_valid, err_avail}, 26'h3);
        check("error code", {10'h0, err_code}, {10'h0, e});
        @(posedge sys_clk) #1 err_pop = 1'b1;
        @(posedge sys_clk) #1 err_pop = 1'b0;
    endtask : err
    task fc(input logic [TIM_W-1:0] e);
        cmd(OP_DWELL_FILL_COUNT_READ, '0, '0, '0, '0);
        want(1, e, '0, '0);
    endtask : fc
////////////////////////////////////////////////////////////////////////////////
    task t_width;
        cmd(OP_CURRENT_SAMPLE_INSERT, 13'h2, '0, '0, 16'h5); err(ERR_SETTINGS);
        cmd(OP_SAMPLE_WIDTH_READ, '0, '0, '0, '0); err(ERR_NOT_SET);
        fc(26'h0);
        cmd(OP_DWELL_SERIES_READ, '0, '0, '0, '0); want(1, 26'h0, '0, '0);
        check("empty flag", {25'h0, last_empty}, 26'h1);
        cmd(OP_SAMPLE_WIDTH_SET, '0, '0, SWID_MIN_NS - 26'h1, '0); err(ERR_RANGE);
        cmd(OP_SAMPLE_WIDTH_SET, '0, '0, SWID_MIN_NS, '0);
        cmd(OP_SAMPLE_WIDTH_SET, '0, '0, SWID_MAX_NS, '0); err(ERR_COMMAND);
        cmd(OP_SAMPLE_WIDTH_READ, '0, '0, '0, '0); want(1, SWID_MIN_NS, '0, '0);
    endtask : t_width
    task t_fill;
        logic [TIM_W-1:0] dw [3] = '{DWELL_MIN_NS, DWELL_MAX_NS, 26'h7A120};
        for (int k = 0; k < 3; k++) begin
            cmd(OP_LEVEL_APPEND, '0, '0, '0, LVL_W'(k));
            cmd(OP_DWELL_TIME_APPEND, '0, '0, dw[k], '0);
            if (k == 0) begin
                @(posedge sys_clk) #1 exec_step = 13'h5;
                repeat (2) @(negedge sys_clk);
                check("single dwell", exec_dwell, DWELL_MIN_NS);
            end
        end
        cmd(OP_DWELL_TIME_APPEND, '0, '0, DWELL_MAX_NS + 26'h1, '0); err(ERR_RANGE);
        cmd(OP_DWELL_TIME_APPEND, '0, '0, DWELL_MIN_NS - 26'h1, '0); err(ERR_RANGE);
        fc(26'h3);
        cmd(OP_READBACK_START_SET, 13'h1, '0, '0, '0);
        cmd(OP_READBACK_START_READ, '0, '0, '0, '0); want(1, 26'h1, '0, '0);
        cmd(OP_DWELL_SERIES_READ, '0, '0, '0, '0); want(2, DWELL_MAX_NS, 26'h7A120, '0);
    endtask : t_fill
    task t_copy;
        cmd(OP_SEGMENT_COPY_APPEND, 13'h0, 13'h1, '0, 16'h7); fc(26'h5);
        cmd(OP_SEGMENT_COPY_APPEND, 13'h0, 13'h5, '0, 16'h7); err(ERR_SETTINGS);
        cmd(OP_SEGMENT_COPY_APPEND, 13'h2, 13'h1, '0, 16'h7); err(ERR_SETTINGS);
        cmd(OP_LEVEL_APPEND, '0, '0, '0, 16'h8);
        cmd(OP_SEGMENT_COPY_APPEND, 13'h0, 13'h1, '0, 16'h7); err(ERR_LENGTH);
        cmd(OP_CURRENT_SAMPLE_INSERT, 13'h2, '0, '0, 16'h9); err(ERR_LENGTH);
        cmd(OP_DWELL_TIME_APPEND, '0, '0, DWELL_MIN_NS, '0); fc(26'h6);
    endtask : t_copy
    task t_sample;
        cmd(OP_CURRENT_SAMPLE_INSERT, 13'h3, '0, '0, 16'h9); fc(26'h8);
        cmd(OP_SAMPLE_POINTS_READ, '0, '0, '0, '0); want(1, 26'h6, '0, '0);
        check("list tag", {18'h0, last_tag}, {18'h0, TAG_CURR});
        // The oversized request must be cut down to the largest permitted count.
        cmd(OP_VOLTAGE_SAMPLE_INSERT, 13'h12C, '0, '0, 16'h9); fc(26'h108);
        for (int k = 0; k < 6; k++) cmd(OP_VOLTAGE_SAMPLE_INSERT, 13'h2, '0, '0, 16'h9);
        fc(26'h114);
        cmd(OP_CURRENT_SAMPLE_INSERT, 13'h2, '0, '0, 16'h9); err(ERR_TOO_MUCH);
        fc(26'h114);
        cmd(OP_SAMPLE_POINTS_READ, '0, '0, '0, '0); want(8, 26'h6, 26'h8, 26'h108);
        check("list tag", {18'h0, last_tag}, {18'h0, TAG_VOLT});
    endtask : t_sample
    task t_res_run;
        cmd(OP_RESOLUTION_READ, '0, '0, '0, '0); want(3, DWELL_MIN_NS, DWELL_MAX_NS, {13'h0, CAP_MIN_RES});
        @(posedge sys_clk) #1 res_max = 1'b1;
        cmd(OP_RESOLUTION_READ, '0, '0, '0, '0); want(3, DWELL_MAX_NS, DWELL_MIN_NS, {13'h0, CAP_MAX_RES});
        @(posedge sys_clk) #1 exec_step = 13'h3;
        repeat (2) @(negedge sys_clk);
        check("paired dwell", exec_dwell, DWELL_MIN_NS);
        cmd(OP_DWELL_SERIES_READ, '0, '0, '0, '0); want(16, DWELL_MAX_NS, 26'h7A120, DWELL_MIN_NS);
        @(posedge sys_clk) #1 list_run = 1'b1;
        cmd(OP_DWELL_FILL_COUNT_READ, '0, '0, '0, '0); err(ERR_SETTINGS);
        @(posedge sys_clk) #1 list_run = 1'b0;
        fc(26'h114);
    endtask : t_res_run
////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 rstn = 1'b1;
        t_width();
        t_fill();
        t_copy();
        t_sample();
        t_res_run();
        stop_test();
    end
endmodule : testbench
